// ===== rtl/sbpwm_chan.sv
// One modulator channel: duty buffer and time-base compare
`timescale 1ns/1ps
module sbpwm_chan (
    input wire logic pclk,
    input wire logic presetn,
    sbpwm_chan_if.chan ch
);
    import sbpwm_pkg::*;

    sbpwm_duty_t duty_buf_q;
    logic level_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            duty_buf_q <= SBPWM_DUTY_RESET;
        end else if (!ch.hold && ch.restart) begin
            duty_buf_q <= ch.duty;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_q <= 1'b0;
        end else if (ch.hold) begin
            level_q <= level_q;
        end else if (!ch.enable) begin
            level_q <= 1'b0;
        end else if (ch.restart) begin
            level_q <= (ch.duty != SBPWM_DUTY_RESET);
        end else if (ch.timebase == duty_buf_q) begin
            // clear on duty match; no match keeps level
            level_q <= 1'b0;
        end
    end

    assign ch.level = level_q;
    assign ch.duty_zero = (duty_buf_q == SBPWM_DUTY_RESET);
endmodule

// ===== rtl/sbpwm_chan_if.sv
// Link between the register block and one modulator channel
`timescale 1ns/1ps
interface sbpwm_chan_if;
    import sbpwm_pkg::*;
    logic enable;
    sbpwm_duty_t duty;
    sbpwm_duty_t timebase;
    logic restart;
    logic hold;
    logic level;
    logic duty_zero;

    modport regs (
        output enable, duty, timebase, restart, hold,
        input level, duty_zero
    );
    modport chan (
        input enable, duty, timebase, restart, hold,
        output level, duty_zero
    );
endinterface

// ===== rtl/sbpwm_pkg.sv
// Constants and types shared by the shared-timebase modulator files
package sbpwm_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int SBPWM_CHANNELS = 2;
    localparam int SBPWM_ADDR_W = 12;
    localparam int SBPWM_DATA_W = 32;
    localparam int SBPWM_DUTY_W = 10;
    localparam int SBPWM_CNT_W = 8;
    localparam int SBPWM_PHASE_W = 2;

    typedef logic [SBPWM_DUTY_W-1:0] sbpwm_duty_t;
    typedef logic [SBPWM_CNT_W-1:0] sbpwm_cnt_t;
    typedef logic [SBPWM_PHASE_W-1:0] sbpwm_phase_t;
    typedef logic [SBPWM_ADDR_W-3:0] sbpwm_idx_t;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam sbpwm_idx_t SBPWM_IDX_DUTY_A = 10'h314;
    localparam sbpwm_idx_t SBPWM_IDX_CTRL_A = 10'h316;
    localparam sbpwm_idx_t SBPWM_IDX_DUTY_B = 10'h318;
    localparam sbpwm_idx_t SBPWM_IDX_CTRL_B = 10'h31a;
    localparam sbpwm_idx_t SBPWM_IDX_RES = 10'h31c;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SBPWM_CTRL_EN_BIT = 7;
    localparam int SBPWM_CTRL_OUT_BIT = 5;
    localparam int SBPWM_CTRL_POL_BIT = 4;
    localparam int SBPWM_DCH_LSB = 8;
    localparam int SBPWM_DCL_LSB = 6;
    localparam int SBPWM_RES_MSB = 3;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] SBPWM_CTRL_RESET = 8'h00;
    localparam sbpwm_duty_t SBPWM_DUTY_RESET = 10'h000;
    localparam logic [3:0] SBPWM_RES_FIXED = 4'h2;

endpackage

// ===== rtl/sbpwm_tbase.sv
// Time base taken from the shared period timer
`timescale 1ns/1ps
module sbpwm_tbase (
    input wire logic pclk,
    input wire logic presetn,
    input wire sbpwm_pkg::sbpwm_cnt_t timer_count,
    input wire sbpwm_pkg::sbpwm_phase_t timer_phase,
    input wire logic timer_tick,
    input wire sbpwm_pkg::sbpwm_cnt_t period_value,
    input wire logic hold,
    output sbpwm_pkg::sbpwm_duty_t timebase_q,
    output logic restart_q
);
    import sbpwm_pkg::*;

    logic restart_p_q;

    // count, increment and phase from timer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timebase_q <= SBPWM_DUTY_RESET;
        end else if (!hold) begin
            timebase_q <= {timer_count, timer_phase};
        end
    end

    // match restarts next increment; postscaler unused
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            restart_p_q <= 1'b0;
        end else if (!hold) begin
            restart_p_q <= timer_tick && (timer_count == period_value);
        end
    end

    // Second stage lines restart up with the registered time base,
    // so set and clear share one lag and the width is the duty
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            restart_q <= 1'b0;
        end else if (!hold) begin
            restart_q <= restart_p_q;
        end
    end
endmodule

// ===== rtl/sbpwm_top.sv
// Shared-timebase modulator pair with its register block
//
// Notes on behaviour
// - Polarity bit set inverts the output
// - Enable bit runs the channel
// - Output level bit is read-only readback
// - Period follows timer period value
// - Count clears the increment after match
// - Restart drives active unless duty zero
// - Duty buffers reload at each restart
// - Timer postscaler has no effect
// - Duty is ten bits over two bytes
// - Time base is count plus phase
// - Duty above period never clears output
// - Resolution is log2 of four periods
// - Sleep holds timer, state and pin
// - Reset clears registers, pins become inputs
// - Each channel clears on its own duty
// - Both channels share one period timer
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
module sbpwm_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [sbpwm_pkg::SBPWM_ADDR_W-1:0] paddr,
    input wire logic [sbpwm_pkg::SBPWM_DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [sbpwm_pkg::SBPWM_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire sbpwm_pkg::sbpwm_cnt_t timer_count,
    input wire sbpwm_pkg::sbpwm_phase_t timer_phase,
    input wire logic timer_tick,
    input wire sbpwm_pkg::sbpwm_cnt_t period_value,
    input wire logic sleep_hold,
    output logic [sbpwm_pkg::SBPWM_CHANNELS-1:0] pwm_out,
    output logic [sbpwm_pkg::SBPWM_CHANNELS-1:0] pwm_oe
);
    import sbpwm_pkg::*;

    // ------------------------------------------------------------
    // Address decoding
    // ------------------------------------------------------------

    // Channel number of a duty index, or -1 when not a duty index
    function automatic int duty_chan(input sbpwm_idx_t idx);
        if (idx == SBPWM_IDX_DUTY_A) begin
            return 0;
        end else if (idx == SBPWM_IDX_DUTY_B) begin
            return 1;
        end else begin
            return -1;
        end
    endfunction

    // Channel number of a control index, or -1
    function automatic int ctrl_chan(input sbpwm_idx_t idx);
        if (idx == SBPWM_IDX_CTRL_A) begin
            return 0;
        end else if (idx == SBPWM_IDX_CTRL_B) begin
            return 1;
        end else begin
            return -1;
        end
    endfunction

    // Floor of log2 of a nonzero nine-bit value
    function automatic logic [3:0] msb_pos(input logic [8:0] v);
        logic [3:0] pos;
        pos = 4'h0;
        for (int i = 0; i < 9; i++) begin
            if (v[i]) begin
                pos = 4'(i);
            end
        end
        return pos;
    endfunction

    sbpwm_idx_t acc_idx;
    logic acc_low_bits;
    logic acc_mapped;
    logic acc_write;
    logic acc_read;
    int acc_duty_ch;
    int acc_ctrl_ch;

    // Word index; nonzero low address bits make the access unmapped
    assign acc_idx = paddr[SBPWM_ADDR_W-1:2];
    assign acc_low_bits = |paddr[1:0];
    assign acc_duty_ch = duty_chan(acc_idx);
    assign acc_ctrl_ch = ctrl_chan(acc_idx);
    assign acc_mapped = !acc_low_bits
        && (acc_duty_ch >= 0 || acc_ctrl_ch >= 0 || acc_idx == SBPWM_IDX_RES);

    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------

    // One wait state: read data is prepared in the first access cycle
    // and the answer stands in the second; this keeps the read mux off
    // the path from paddr to the bus outputs.
    logic pready_q;
    logic pslverr_q;
    logic [SBPWM_DATA_W-1:0] prdata_q;
    logic access_first;
    logic access_done;

    assign access_first = psel && penable && !pready_q;
    assign access_done = psel && penable && pready_q;
    assign acc_write = access_done && pwrite && acc_mapped;
    assign acc_read = access_first && !pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= access_first;
        end
    end

    // Misaligned or unmapped word answers with an error, no effect
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_q <= 1'b0;
        end else begin
            pslverr_q <= access_first && !acc_mapped;
        end
    end

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------

    sbpwm_duty_t duty_q [SBPWM_CHANNELS];
    logic [SBPWM_CHANNELS-1:0] enable_q;
    logic [SBPWM_CHANNELS-1:0] invert_q;
    logic [SBPWM_CHANNELS-1:0] level;
    logic [SBPWM_CHANNELS-1:0] duty_zero;
    logic [SBPWM_CHANNELS-1:0] pwm_out_q;
    logic [SBPWM_CHANNELS-1:0] pwm_oe_q;
    logic [3:0] res_bits_q;
    sbpwm_duty_t timebase;
    logic restart;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int c = 0; c < SBPWM_CHANNELS; c++) begin
                duty_q[c] <= SBPWM_DUTY_RESET;
            end
        end else if (acc_write && acc_duty_ch >= 0) begin
            if (pstrb[1]) begin
                duty_q[acc_duty_ch][SBPWM_DUTY_W-1:2] <=
                    pwdata[SBPWM_DCH_LSB+7:SBPWM_DCH_LSB];
            end
            if (pstrb[0]) begin
                duty_q[acc_duty_ch][1:0] <= pwdata[SBPWM_DCL_LSB+1:SBPWM_DCL_LSB];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_q <= SBPWM_CTRL_RESET[SBPWM_CHANNELS-1:0];
        end else if (acc_write && acc_ctrl_ch >= 0 && pstrb[0]) begin
            enable_q[acc_ctrl_ch] <= pwdata[SBPWM_CTRL_EN_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            invert_q <= SBPWM_CTRL_RESET[SBPWM_CHANNELS-1:0];
        end else if (acc_write && acc_ctrl_ch >= 0 && pstrb[0]) begin
            invert_q[acc_ctrl_ch] <= pwdata[SBPWM_CTRL_POL_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            res_bits_q <= SBPWM_RES_FIXED;
        end else begin
            res_bits_q <= SBPWM_RES_FIXED + msb_pos({1'b0, period_value} + 9'h001);
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------

    logic [SBPWM_DATA_W-1:0] rd_word;

    always_comb begin
        rd_word = '0;
        if (acc_duty_ch >= 0) begin
            rd_word[SBPWM_DCH_LSB+7:SBPWM_DCH_LSB] = duty_q[acc_duty_ch][SBPWM_DUTY_W-1:2];
            rd_word[SBPWM_DCL_LSB+1:SBPWM_DCL_LSB] = duty_q[acc_duty_ch][1:0];
        end else if (acc_ctrl_ch >= 0) begin
            rd_word[SBPWM_CTRL_EN_BIT] = enable_q[acc_ctrl_ch];
            rd_word[SBPWM_CTRL_OUT_BIT] = pwm_out_q[acc_ctrl_ch];
            rd_word[SBPWM_CTRL_POL_BIT] = invert_q[acc_ctrl_ch];
        end else if (acc_idx == SBPWM_IDX_RES) begin
            rd_word[SBPWM_RES_MSB:0] = res_bits_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= '0;
        end else if (acc_read && acc_mapped) begin
            prdata_q <= rd_word;
        end else if (access_first) begin
            prdata_q <= '0;
        end
    end

    // ------------------------------------------------------------
    // Shared time base
    // ------------------------------------------------------------

    // one timer for both; period from period value
    sbpwm_tbase u_tbase (
        .pclk(pclk),
        .presetn(presetn),
        .timer_count(timer_count),
        .timer_phase(timer_phase),
        .timer_tick(timer_tick),
        .period_value(period_value),
        .hold(sleep_hold),
        .timebase_q(timebase),
        .restart_q(restart)
    );

    // ------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------

    sbpwm_chan_if chan_if [SBPWM_CHANNELS] ();

    generate
        for (genvar g = 0; g < SBPWM_CHANNELS; g++) begin : g_chan
            assign chan_if[g].enable = enable_q[g];
            assign chan_if[g].duty = duty_q[g];
            assign chan_if[g].timebase = timebase;
            assign chan_if[g].restart = restart;
            assign chan_if[g].hold = sleep_hold;
            assign level[g] = chan_if[g].level;
            assign duty_zero[g] = chan_if[g].duty_zero;

            sbpwm_chan u_chan (
                .pclk(pclk),
                .presetn(presetn),
                .ch(chan_if[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Pins
    // ------------------------------------------------------------

    // Inversion sits after the level so a disabled channel still
    // shows its idle level through the polarity choice.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_out_q <= '0;
        end else if (!sleep_hold) begin
            pwm_out_q <= level ^ invert_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_oe_q <= '0;
        end else if (!sleep_hold) begin
            pwm_oe_q <= enable_q;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign pwm_out = pwm_out_q;
    assign pwm_oe = pwm_oe_q;

endmodule

// ===== sim/sbpwm_bench.sv
// Self-checking bench for the modulator pair
`timescale 1ns/1ps
module sbpwm_bench;
    import sbpwm_pkg::*;
    localparam int PR = 7;
    localparam int PLEN = 4 * (PR + 1);
    localparam logic [11:0] DUTY_A = {SBPWM_IDX_DUTY_A, 2'h0};
    localparam logic [11:0] CTRL_A = {SBPWM_IDX_CTRL_A, 2'h0};
    localparam logic [11:0] DUTY_B = {SBPWM_IDX_DUTY_B, 2'h0};
    localparam logic [11:0] CTRL_B = {SBPWM_IDX_CTRL_B, 2'h0};
    localparam logic [11:0] RES = {SBPWM_IDX_RES, 2'h0};
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic sleep_hold = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, perr, timer_tick;
    sbpwm_cnt_t timer_count;
    sbpwm_phase_t timer_phase;
    sbpwm_cnt_t period_value = 8'h07;
    logic [1:0] pwm_out, pwm_oe, s;
    logic [15:0] lfsr = 16'h7563;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;
    int cases[$] = '{0, 5, PLEN - 1, PLEN, 1023};

    always #2.5 pclk = ~pclk;

    sbpwm_top u_sbpwm_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer_count(timer_count),
        .timer_phase(timer_phase), .timer_tick(timer_tick), .period_value(period_value),
        .sleep_hold(sleep_hold), .pwm_out(pwm_out), .pwm_oe(pwm_oe));
    sbpwm_ptimer u_sbpwm_ptimer (.pclk(pclk), .presetn(presetn), .period_value(period_value),
        .sleep_hold(sleep_hold), .timer_count(timer_count), .timer_phase(timer_phase),
        .timer_tick(timer_tick));

    function automatic logic [15:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction
    // Expected active cycles in one period
    function automatic int exp_hi(input int d);
        if (d == 0) begin
            return 0;
        end
        return (d >= PLEN) ? PLEN : d;
    endfunction
    task automatic finish_test;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hf;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 16);
        if (pready !== 1'h1) begin
            errors++;
        end
        rd = prdata;
        perr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    // Program both channels, settle, count active cycles over one period
    task automatic meas(input int d, input logic [1:0] output_invert);
        int ha, hb, db;
        ha = 0;
        hb = 0;
        db = (d * 3) % 1024;
        // control written after the duty step
        apb(1'h1, DUTY_A, 32'(d) << 6);
        apb(1'h1, DUTY_B, 32'(db) << 6);
        apb(1'h1, CTRL_A, {24'h0, 1'h1, 2'h0, output_invert[0], 4'h0});
        apb(1'h1, CTRL_B, {24'h0, 1'h1, 2'h0, output_invert[1], 4'h0});
        apb(1'h0, DUTY_A, 32'h0);
        chk(rd, 32'(d) << 6, "duty readback");
        repeat (3 * PLEN) @(posedge pclk);
        repeat (PLEN) begin
            @(posedge pclk);
            ha += int'(pwm_out[0] === 1'h1);
            hb += int'(pwm_out[1] === 1'h1);
        end
        chk(ha, output_invert[0] ? PLEN - exp_hi(d) : exp_hi(d), "width a");
        chk(hb, output_invert[1] ? PLEN - exp_hi(db) : exp_hi(db), "width b");
    endtask

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            finish_test;
        end
    end

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
        // period fixed before any channel is enabled
        apb(1'h0, CTRL_A, 32'h0);
        chk(rd, 32'h0, "ctrl a reset");
        apb(1'h0, CTRL_B, 32'h0);
        chk(rd, 32'h0, "ctrl b reset");
        apb(1'h0, RES, 32'h0);
        chk(rd, 32'h5, "resolution");
        apb(1'h0, 12'h000, 32'h0);
        chk(perr, 1'h1, "unmapped");
        apb(1'h1, CTRL_A + 12'h001, 32'hff);
        chk(perr, 1'h1, "misaligned");
        $display("test reset done");
        repeat (3) cases.push_back(int'(rnd()) % PLEN);
        foreach (cases[i]) begin
            meas(cases[i], 2'(rnd()));
        end
        $display("test widths done");
        apb(1'h1, DUTY_A, 32'h0);
        apb(1'h1, CTRL_A, 32'hff);
        repeat (2 * PLEN) @(posedge pclk);
        chk(pwm_out[0], 1'h1, "inverted idle");
        apb(1'h0, CTRL_A, 32'h0);
        chk(rd, 32'hb0, "ctrl readback");
        $display("test readback done");
        meas(10, 2'h0);
        sleep_hold <= 1'h1;
        repeat (5) @(posedge pclk);
        s = pwm_out;
        repeat (40) @(posedge pclk);
        chk(pwm_out, s, "sleep hold");
        sleep_hold <= 1'h0;
        meas(10, 2'h0);
        $display("test sleep done");
        apb(1'h1, CTRL_A, 32'h0);
        apb(1'h1, CTRL_B, 32'h0);
        repeat (2 * PLEN) @(posedge pclk);
        chk(pwm_oe, 2'h0, "oe off");
        chk(pwm_out, 2'h0, "disabled level");
        meas(20, 2'h3);
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        chk(pwm_oe, 2'h0, "oe in reset");
        presetn <= 1'h1;
        apb(1'h0, CTRL_B, 32'h0);
        chk(rd, 32'h0, "ctrl after reset");
        $display("test disable and reset done");
        finish_test;
    end
endmodule

bind sbpwm_top sbpwm_top_props u_sbpwm_top_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep_hold(sleep_hold),
    .pwm_out(pwm_out), .pwm_oe(pwm_oe));

// ===== sim/sbpwm_ptimer.sv
// Behavioural shared period timer feeding the modulator pair
`timescale 1ns/1ps
module sbpwm_ptimer (
    input wire logic pclk,
    input wire logic presetn,
    input wire sbpwm_pkg::sbpwm_cnt_t period_value,
    input wire logic sleep_hold,
    output sbpwm_pkg::sbpwm_cnt_t timer_count,
    output sbpwm_pkg::sbpwm_phase_t timer_phase,
    output logic timer_tick
);
    import sbpwm_pkg::*;
    assign timer_tick = timer_phase == 2'h3 && !sleep_hold;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_phase <= 2'h0;
        end else if (!sleep_hold) begin
            timer_phase <= timer_phase + 2'h1;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_count <= 8'h00;
        end else if (timer_tick) begin
            timer_count <= (timer_count == period_value) ? 8'h00 : timer_count + 8'h01;
        end
    end
endmodule

// ===== sim/sbpwm_top_props.sv
// Port assertions for the modulator pair
`timescale 1ns/1ps
module sbpwm_top_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [sbpwm_pkg::SBPWM_ADDR_W-1:0] paddr,
    input wire logic [sbpwm_pkg::SBPWM_DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [sbpwm_pkg::SBPWM_DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sleep_hold,
    input wire logic [1:0] pwm_out,
    input wire logic [1:0] pwm_oe
);
    import sbpwm_pkg::*;
    localparam logic [11:0] CTRL_A = {SBPWM_IDX_CTRL_A, 2'h0};
    logic wr_a;
    assign wr_a = psel && penable && pready && pwrite && !pslverr && paddr == CTRL_A && pstrb[0];
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_ready_next: assert property (psel && penable && !pready |=> pready)
        else $error("no answer one cycle after access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held past one cycle");
    a_err_misalign: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access not refused");
    a_err_rdzero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    a_ctrl_read: assert property (
        pready && !pwrite && paddr == CTRL_A |-> !pslverr && prdata[31:8] == 24'h0
        && prdata[6] == 1'h0 && prdata[3:0] == 4'h0) else $error("control read bad bits");
    a_oe_follow: assert property (wr_a |-> ##2 pwm_oe[0] == $past(pwdata[7], 2))
        else $error("enable does not reach output enable");
    a_sleep_hold: assert property (sleep_hold [*4] |-> $stable(pwm_out) && $stable(pwm_oe))
        else $error("outputs moved in sleep");
    a_reset_quiet: assert property ($rose(presetn) |-> pwm_oe == 2'h0 && pwm_out == 2'h0)
        else $error("outputs active after reset");
endmodule
